// [shared/ahs_pkg.sv]
// Constants and types for the host sequencer, shadow and device-signal block
package ahs_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [15:0] AHS_ADDR_SEQ    = 16'hFF96;
  localparam logic [15:0] AHS_ADDR_SH_STATUS = 16'hFF97;
  localparam logic [15:0] AHS_ADDR_SH_ERROR  = 16'hFF98;
  localparam logic [15:0] AHS_ADDR_DEV    = 16'hFF99;
  // ----------------------------------------
  // Sequencer control bits
  // ----------------------------------------
  localparam int AHS_SEQ_PKT_EN  = 7;
  localparam int AHS_SEQ_DRQ_EN  = 6;
  localparam int AHS_SEQ_CMPL_EN = 5;
  localparam int AHS_SEQ_CMPL_ER = 4;
  localparam int AHS_SEQ_SUSP    = 3;
  localparam int AHS_SEQ_REPEAT  = 2;
  localparam logic [7:0] AHS_SEQ_WMASK = 8'hFC;
  // ----------------------------------------
  // Shadow and device-signal bits
  // ----------------------------------------
  localparam int AHS_SH_CHECK    = 0;
  localparam int AHS_SH_ABORT    = 2;
  localparam int AHS_DEV_DIAG_O  = 7;
  localparam int AHS_DEV_DIAG_EN = 6;
  localparam int AHS_DEV_SLV_O   = 5;
  localparam int AHS_DEV_SLV_EN  = 4;
  localparam int AHS_DEV_DIAG_I  = 3;
  localparam int AHS_DEV_SLV_I   = 2;
  localparam int AHS_DEV_HIPRI   = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] AHS_SEQ_RST = 8'h00;
  localparam logic [7:0] AHS_DEV_RST = 8'h00;

  typedef enum logic [2:0] {
    AHS_ST_IDLE,
    AHS_ST_PKT,
    AHS_ST_DRQ,
    AHS_ST_CMPL,
    AHS_ST_RST
  } ahs_seq_state_t;
endpackage : ahs_pkg

// [shared/ahs_seq_if.sv]
// Link between the register file and the auto sequencer
`timescale 1ns/1ps
interface ahs_seq_if;
  import ahs_pkg::*;
  logic           pkt_en;
  logic           drq_en;
  logic           cmpl_en;
  logic           cmpl_err;
  logic           suspend;
  logic           pkt_end;
  logic           seq_reset;
  logic           alt_wr;
  logic           alt_check;
  logic           drq;
  ahs_seq_state_t state;
  modport ctrl (output pkt_en, drq_en, cmpl_en, cmpl_err, suspend,
                input  pkt_end, seq_reset, alt_wr, alt_check, drq, state);
  modport seq  (input  pkt_en, drq_en, cmpl_en, cmpl_err, suspend,
                output pkt_end, seq_reset, alt_wr, alt_check, drq, state);
endinterface : ahs_seq_if

// [verilog/ahs_pin_sync.sv]
// Two-stage synchroniser for the diagnostics and slave-present pins
`timescale 1ns/1ps
module ahs_pin_sync (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_sync
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } ahs_sync_st_t;

  ahs_sync_st_t q;
  ahs_sync_st_t d;

  // Only the second stage is visible outside
  always_comb begin
    d      = q;
    d.meta = pin_in;
    d.sync = q.meta;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_sync = q.sync;
endmodule : ahs_pin_sync

// [verilog/ahs_auto_seq.sv]
// Auto sequencer: packet reception, data request and completion
`timescale 1ns/1ps
module ahs_auto_seq
  import ahs_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pkt_done,
  input  wire logic xfer_done,
  ahs_seq_if.seq    sq
);
  typedef struct packed {
    ahs_seq_state_t state;
    logic           pkt_end;
    logic           seq_reset;
    logic           alt_wr;
    logic           alt_check;
    logic           drq;
  } ahs_seq_st_t;

  ahs_seq_st_t q;
  ahs_seq_st_t d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d           = q;
    d.pkt_end   = 1'b0;
    d.seq_reset = 1'b0;
    d.alt_wr    = 1'b0;
    if (!sq.suspend) begin
      case (q.state)
        // Enables are cleared one cycle after the end pulses, so wait
        AHS_ST_IDLE: begin
          if (!q.pkt_end && !q.seq_reset) begin
            if (sq.pkt_en) begin
              d.state = AHS_ST_PKT;
            end else if (sq.drq_en) begin
              d.state = AHS_ST_DRQ;
            end
          end
        end
        AHS_ST_PKT: begin
          if (pkt_done) begin
            d.pkt_end = 1'b1;
            d.state   = AHS_ST_IDLE;
          end
        end
        AHS_ST_DRQ: begin
          if (xfer_done) begin
            d.state = sq.cmpl_en ? AHS_ST_CMPL : AHS_ST_RST;
          end
        end
        // status write carries the error bit
        AHS_ST_CMPL: begin
          d.alt_wr    = 1'b1;
          d.alt_check = sq.cmpl_err;
          d.state     = AHS_ST_RST;
        end
        AHS_ST_RST: begin
          d.seq_reset = 1'b1;
          d.state     = AHS_ST_IDLE;
        end
        default: begin
          d.state = AHS_ST_IDLE;
        end
      endcase
    end
    d.drq = (d.state == AHS_ST_DRQ);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sq.pkt_end   = q.pkt_end;
  assign sq.seq_reset = q.seq_reset;
  assign sq.alt_wr    = q.alt_wr;
  assign sq.alt_check = q.alt_check;
  assign sq.drq       = q.drq;
  assign sq.state     = q.state;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_check_bit_copy: assert property (
    sq.alt_wr |-> sq.alt_check == $past(sq.cmpl_err))
    else $error("Completion check bit differs from error control");
  a_suspend_freeze: assert property (
    sq.suspend |=> q.state == $past(q.state))
    else $error("Sequencer moved while suspended");
  a_write_held: assert property (
    $past(sq.suspend) |-> !sq.alt_wr)
    else $error("Status write performed while suspended");
endmodule : ahs_auto_seq

// [verilog/ahs_top.sv]
// Host sequencer control, shadow registers and device-signal pins
`timescale 1ns/1ps
module ahs_top
  import ahs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rd_data,
  input  wire logic        shadow_mode,
  input  wire logic        pkt_done,
  input  wire logic        xfer_done,
  input  wire logic        diag_pin_i,
  output logic             diag_pin_o,
  output logic             diag_pin_oe,
  input  wire logic        slave_pin_i,
  output logic             slave_pin_o,
  output logic             slave_pin_oe,
  output logic             shadow_check,
  output logic             shadow_abort,
  output logic             alt_status_wr,
  output logic             alt_status_check,
  output logic             data_request,
  output logic             host_high_priority
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] seq;
    logic       sh_check;
    logic       sh_abort;
    logic       sh_abort_vis;
    logic       diag_o;
    logic       diag_en;
    logic       slv_o;
    logic       slv_en;
    logic       hipri;
    logic [7:0] rd_data;
  } ahs_top_st_t;

  ahs_top_st_t q;
  ahs_top_st_t d;
  logic [1:0]  pins_s;

  ahs_seq_if sq ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(
    input logic [15:0] a,
    input logic [15:0] off
  );
    hit = (a == off);
  endfunction : hit

  function automatic logic sw_sets(
    input logic        we,
    input logic [15:0] a,
    input logic [7:0]  wd,
    input int          pos
  );
    sw_sets = we && hit(a, AHS_ADDR_SEQ) && wd[pos];
  endfunction : sw_sets

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  // Pins come from the cable, so they are synchronised first
  ahs_pin_sync u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .pin_in   ({slave_pin_i, diag_pin_i}),
    .pin_sync (pins_s)
  );

  ahs_auto_seq u_seq (
    .clock     (clock),
    .rst_n     (rst_n),
    .pkt_done  (pkt_done),
    .xfer_done (xfer_done),
    .sq        (sq.seq)
  );

  assign sq.pkt_en   = q.seq[AHS_SEQ_PKT_EN];
  assign sq.drq_en   = q.seq[AHS_SEQ_DRQ_EN];
  assign sq.cmpl_en  = q.seq[AHS_SEQ_CMPL_EN];
  assign sq.cmpl_err = q.seq[AHS_SEQ_CMPL_ER];
  assign sq.suspend  = q.seq[AHS_SEQ_SUSP];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    d         = q;
    d.rd_data = 8'h00;
    if (wr_en) begin
      if (hit(addr, AHS_ADDR_SEQ)) begin
        d.seq = wr_data & AHS_SEQ_WMASK;
      end
      if (hit(addr, AHS_ADDR_SH_STATUS)) begin
        d.sh_check = wr_data[AHS_SH_CHECK];
      end
      if (hit(addr, AHS_ADDR_SH_ERROR)) begin
        d.sh_abort = wr_data[AHS_SH_ABORT];
      end
      // enable bit turns the driver on
      // bits 3 to 1 are not writable
      if (hit(addr, AHS_ADDR_DEV)) begin
        d.diag_o  = wr_data[AHS_DEV_DIAG_O];
        d.diag_en = wr_data[AHS_DEV_DIAG_EN];
        d.slv_o   = wr_data[AHS_DEV_SLV_O];
        d.slv_en  = wr_data[AHS_DEV_SLV_EN];
        d.hipri   = wr_data[AHS_DEV_HIPRI];
      end
    end
    // one extra reception only, a same-cycle write of one wins
    if (sq.pkt_end) begin
      if (!sw_sets(wr_en, addr, wr_data, AHS_SEQ_REPEAT)) begin
        d.seq[AHS_SEQ_REPEAT] = 1'b0;
      end
      if (!sw_sets(wr_en, addr, wr_data, AHS_SEQ_PKT_EN)) begin
        d.seq[AHS_SEQ_PKT_EN] = 1'b0;
      end
    end
    if (sq.seq_reset) begin
      d.seq[AHS_SEQ_PKT_EN] = q.seq[AHS_SEQ_REPEAT]
        | sw_sets(wr_en, addr, wr_data, AHS_SEQ_PKT_EN);
      if (!sw_sets(wr_en, addr, wr_data, AHS_SEQ_DRQ_EN)) begin
        d.seq[AHS_SEQ_DRQ_EN] = 1'b0;
      end
    end
    // host sees abort only in shadow mode
    d.sh_abort_vis = shadow_mode & d.sh_abort;
    if (rd_en) begin
      if (hit(addr, AHS_ADDR_SEQ)) begin
        d.rd_data = q.seq;
      end
      // sampled diagnostics pin on bit 3
      // sampled slave-present pin on bit 2
      if (hit(addr, AHS_ADDR_DEV)) begin
        d.rd_data = {q.diag_o, q.diag_en, q.slv_o, q.slv_en,
                     pins_s[0], pins_s[1], 1'b0, q.hipri};
      end
    end
  end

  // pad enables clear, pins start as inputs
  // shadow images change only by write or reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data            = q.rd_data;
  // driven level follows the output bit
  assign diag_pin_o         = q.diag_o;
  assign diag_pin_oe        = q.diag_en;
  assign slave_pin_o        = q.slv_o;
  assign slave_pin_oe       = q.slv_en;
  assign shadow_check       = q.sh_check;
  assign shadow_abort       = q.sh_abort_vis;
  assign alt_status_wr      = sq.alt_wr;
  assign alt_status_check   = sq.alt_check;
  assign data_request       = sq.drq;
  assign host_high_priority = q.hipri;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_dev_write_en;
    wr_en && hit(addr, AHS_ADDR_DEV) && wr_data[AHS_DEV_DIAG_EN];
  endsequence

  sequence s_seq_quiet;
    !(wr_en && hit(addr, AHS_ADDR_SEQ));
  endsequence

  sequence s_dev_read;
    rd_en && hit(addr, AHS_ADDR_DEV);
  endsequence

  sequence s_dev_write_off;
    wr_en && hit(addr, AHS_ADDR_DEV) && !wr_data[AHS_DEV_DIAG_EN];
  endsequence

  sequence s_err_write;
    wr_en && hit(addr, AHS_ADDR_SH_ERROR);
  endsequence

  // ----------------------------------------
  // Register and sequencer checks
  // ----------------------------------------

  a_repeat_copy: assert property (
    sq.seq_reset and s_seq_quiet
    |=> q.seq[AHS_SEQ_PKT_EN] == $past(q.seq[AHS_SEQ_REPEAT]))
    else $error("Repeat bit not copied at sequencer reset");
  a_repeat_clear: assert property (
    sq.pkt_end and s_seq_quiet |=> !q.seq[AHS_SEQ_REPEAT])
    else $error("Repeat bit not cleared after packet sequence");
  a_shadow_check: assert property (
    wr_en && hit(addr, AHS_ADDR_SH_STATUS)
    |=> shadow_check == $past(wr_data[AHS_SH_CHECK]))
    else $error("Shadow check bit not taken from bit 0");
  a_abort_gate: assert property (
    !$past(shadow_mode) |-> !shadow_abort)
    else $error("Shadow abort visible outside shadow mode");
  a_diag_drive: assert property (
    s_dev_write_en ##1 1'b1
    |-> diag_pin_oe && diag_pin_o == $past(wr_data[AHS_DEV_DIAG_O]))
    else $error("Diagnostics pin not driven as written");
  a_diag_sample: assert property (
    rd_en && hit(addr, AHS_ADDR_DEV)
    |=> rd_data[AHS_DEV_DIAG_I] == $past(pins_s[0]))
    else $error("Diagnostics input bit wrong");
  a_unused_zero: assert property (
    $past(rd_en) |-> !rd_data[1])
    else $error("Unused bit 1 not zero");
  a_shadow_hold: assert property (
    !(wr_en && hit(addr, AHS_ADDR_SH_ERROR)) |=> $stable(q.sh_abort))
    else $error("Shadow error image changed without write");
  a_wo_read: assert property (
    rd_en && (hit(addr, AHS_ADDR_SH_STATUS) || hit(addr, AHS_ADDR_SH_ERROR))
    |=> rd_data == 8'h00)
    else $error("Write-only register read nonzero");

  // ----------------------------------------
  // Sequencer control, shadow and pin checks
  // ----------------------------------------
  a_drq_clear: assert property (
    sq.seq_reset and s_seq_quiet |=> !q.seq[AHS_SEQ_DRQ_EN])
    else $error("Data request enable not cleared at sequencer reset");

  a_pkt_clear: assert property (
    sq.pkt_end and s_seq_quiet |=> !q.seq[AHS_SEQ_PKT_EN])
    else $error("Packet enable not cleared after packet sequence");

  // Mode is taken registered, the same way the gate takes it
  a_abort_show: assert property (
    $past(shadow_mode) |-> shadow_abort == q.sh_abort)
    else $error("Shadow abort hidden in shadow mode");

  a_abort_bit: assert property (
    s_err_write
    |=> q.sh_abort == $past(wr_data[AHS_SH_ABORT]))
    else $error("Shadow abort not taken from bit 2");

  // Pins must stay inputs until firmware asks for the driver
  a_pad_reset: assert property (
    !$past(rst_n) |-> !diag_pin_oe && !slave_pin_oe)
    else $error("Pad enable set straight after reset");

  // Clearing the enable hands the line back to the cable
  a_diag_release: assert property (
    s_dev_write_off |=> !diag_pin_oe)
    else $error("Diagnostics driver left on after clear");

  // Read back even when driven; only meaningful with bit 4 clear
  a_slave_sample: assert property (
    s_dev_read
    |=> rd_data[AHS_DEV_SLV_I] == $past(pins_s[1]))
    else $error("Slave-present input bit wrong");

  a_check_hold: assert property (
    !(wr_en && hit(addr, AHS_ADDR_SH_STATUS)) |=> $stable(q.sh_check))
    else $error("Shadow status image changed without write");
endmodule : ahs_top

// [test/ahs_host_model.sv]
// Cable-side model of the diagnostics and slave-present lines
`timescale 1ns/1ps
module ahs_host_model (
  input  wire logic diag_pin_o,
  input  wire logic diag_pin_oe,
  input  wire logic slave_pin_o,
  input  wire logic slave_pin_oe,
  input  wire logic diag_ext_low,
  input  wire logic slave_ext_low,
  output logic      diag_pin_i,
  output logic      slave_pin_i
);
  // driven level reaches the line; released line rests at the pull-up
  // another device may pull the shared line low, and low always wins
  assign diag_pin_i  = (diag_pin_oe ? diag_pin_o : 1'b1) & !diag_ext_low;
  assign slave_pin_i = (slave_pin_oe ? slave_pin_o : 1'b1) & !slave_ext_low;
endmodule : ahs_host_model

// [test/ahs_top_test.sv]
// Self-checking bench for the sequencer, shadow and pin block
`timescale 1ns/1ps
module ahs_top_test;
  import ahs_pkg::*;
  logic        clock, rst_n, wr_en, rd_en, shadow_mode, pkt_done, xfer_done;
  logic        diag_ext_low, slave_ext_low, diag_pin_i, diag_pin_o, diag_pin_oe;
  logic        slave_pin_i, slave_pin_o, slave_pin_oe, shadow_check, shadow_abort;
  logic        alt_status_wr, alt_status_check, data_request, host_high_priority;
  logic [15:0] addr;
  logic [7:0]  wr_data, rd_data, rv;
  int          bad_count, checked;

  ahs_top ahs_top_inst (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .shadow_mode(shadow_mode),
    .pkt_done(pkt_done), .xfer_done(xfer_done), .diag_pin_i(diag_pin_i),
    .diag_pin_o(diag_pin_o), .diag_pin_oe(diag_pin_oe), .slave_pin_i(slave_pin_i),
    .slave_pin_o(slave_pin_o), .slave_pin_oe(slave_pin_oe),
    .shadow_check(shadow_check), .shadow_abort(shadow_abort),
    .alt_status_wr(alt_status_wr), .alt_status_check(alt_status_check),
    .data_request(data_request), .host_high_priority(host_high_priority));

  ahs_host_model ahs_host_model_inst (.diag_pin_o(diag_pin_o), .diag_pin_oe(diag_pin_oe),
    .slave_pin_o(slave_pin_o), .slave_pin_oe(slave_pin_oe),
    .diag_ext_low(diag_ext_low), .slave_ext_low(slave_ext_low),
    .diag_pin_i(diag_pin_i), .slave_pin_i(slave_pin_i));

  // ----------------------------------------
  // Helpers; every task that waits on the clock rests at a falling edge so checks see settled values
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rd_data;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle

  task automatic pulse(input int sel);
    @(posedge clock);
    if (sel == 0) pkt_done <= 1'b1;
    else xfer_done <= 1'b1;
    @(posedge clock);
    pkt_done  <= 1'b0;
    xfer_done <= 1'b0;
    @(negedge clock);
  endtask : pulse

  // Bounded wait for data request (0) or the completion write pulse (1)
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (n < 50 && (sel == 0 ? data_request : alt_status_wr) !== 1'b1);
    if ((sel == 0 ? data_request : alt_status_wr) !== 1'b1) begin
      bad_count++;
      $display("[FAIL] t=%0t wait sel=%h exp=%h", $time, sel, 1);
      end_of_test();
    end
  endtask : wait_for

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk1(diag_pin_oe, 1'b0);
    rd(AHS_ADDR_SEQ, rv);
    chk8(rv, AHS_SEQ_RST);
    rd(AHS_ADDR_DEV, rv);
    chk8(rv, 8'h0C);
    rd(16'h1234, rv);
    chk8(rv, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_pins;
    // Open-collector use: output bit stays low, only the enable toggles
    wr(AHS_ADDR_DEV, 8'h40);
    chk1(diag_pin_oe, 1'b1);
    chk1(diag_pin_i, 1'b0);
    wr(AHS_ADDR_DEV, 8'h00);
    chk1(diag_pin_oe, 1'b0);
    diag_ext_low  <= 1'b1;
    slave_ext_low <= 1'b1;
    idle(4);
    rd(AHS_ADDR_DEV, rv);
    chk8(rv, 8'h00);
    diag_ext_low  <= 1'b0;
    slave_ext_low <= 1'b0;
    wr(AHS_ADDR_DEV, 8'hFF);
    chk1(diag_pin_o, 1'b1);
    chk1(host_high_priority, 1'b1);
    chk1(slave_pin_o, 1'b1);
    chk1(slave_pin_oe, 1'b1);
    idle(4);
    rd(AHS_ADDR_DEV, rv);
    chk8(rv, 8'hFD);
    wr(AHS_ADDR_DEV, 8'h00);
    chk1(slave_pin_oe, 1'b0);
    $display("pin test done");
  endtask : t_pins

  task automatic t_shadow;
    wr(AHS_ADDR_SH_STATUS, 8'hFF);
    idle(2);
    chk1(shadow_check, 1'b1);
    rd(AHS_ADDR_SH_STATUS, rv);
    chk8(rv, 8'h00);
    wr(AHS_ADDR_SH_ERROR, 8'h04);
    idle(2);
    chk1(shadow_abort, 1'b0);
    @(posedge clock);
    shadow_mode <= 1'b1;
    idle(3);
    chk1(shadow_abort, 1'b1);
    wr(AHS_ADDR_DEV, 8'h00);
    idle(6);
    chk1(shadow_check, 1'b1);
    chk1(shadow_abort, 1'b1);
    rd(AHS_ADDR_SH_ERROR, rv);
    chk8(rv, 8'h00);
    // Leaving shadow mode hides the flag but keeps the image
    @(posedge clock);
    shadow_mode <= 1'b0;
    idle(3);
    chk1(shadow_abort, 1'b0);
    @(posedge clock);
    shadow_mode <= 1'b1;
    idle(3);
    chk1(shadow_abort, 1'b1);
    wr(AHS_ADDR_SH_STATUS, 8'hFE);
    wr(AHS_ADDR_SH_ERROR, 8'hFB);
    idle(2);
    chk1(shadow_check, 1'b0);
    chk1(shadow_abort, 1'b0);
    $display("shadow test done");
  endtask : t_shadow

  task automatic t_repeat;
    // Data request, completion with error, repeat bit armed
    wr(AHS_ADDR_SEQ, 8'h74);
    wait_for(0);
    pulse(1);
    wait_for(1);
    chk1(alt_status_check, 1'b1);
    idle(4);
    rd(AHS_ADDR_SEQ, rv);
    chk8(rv, 8'hB4);
    pulse(0);
    idle(4);
    rd(AHS_ADDR_SEQ, rv);
    chk8(rv, 8'h30);
    chk1(data_request, 1'b0);
    $display("repeat test done");
  endtask : t_repeat

  task automatic t_suspend;
    int n;
    wr(AHS_ADDR_SEQ, 8'h60);
    wait_for(0);
    // Freeze lands as the machine enters the completion write state
    @(posedge clock);
    xfer_done <= 1'b1;
    addr      <= AHS_ADDR_SEQ;
    wr_data   <= 8'h68;
    wr_en     <= 1'b1;
    @(posedge clock);
    xfer_done <= 1'b0;
    wr_en     <= 1'b0;
    for (n = 0; n < 10; n++) begin
      @(negedge clock);
      chk1(alt_status_wr, 1'b0);
    end
    wr(AHS_ADDR_SEQ, 8'h20);
    wait_for(1);
    chk1(alt_status_check, 1'b0);
    // Without completion enable the machine goes straight to reset
    wr(AHS_ADDR_SEQ, 8'h40);
    wait_for(0);
    pulse(1);
    for (n = 0; n < 4; n++) begin
      @(negedge clock);
      chk1(alt_status_wr, 1'b0);
    end
    rd(AHS_ADDR_SEQ, rv);
    chk8(rv, 8'h00);
    $display("suspend test done");
  endtask : t_suspend

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    rst_n         = 1'b0;
    addr          = 16'h0000;
    wr_data       = 8'h00;
    wr_en         = 1'b0;
    rd_en         = 1'b0;
    shadow_mode   = 1'b0;
    pkt_done      = 1'b0;
    xfer_done     = 1'b0;
    diag_ext_low  = 1'b0;
    slave_ext_low = 1'b0;
    bad_count     = 0;
    checked       = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    t_reset();
    t_pins();
    t_shadow();
    t_repeat();
    t_suspend();
    end_of_test();
  end
endmodule : ahs_top_test
